// *** include/rtid_regs.svh ***
/*
 * Constants of the register-transfer instruction decoder: operation codes,
 * field positions and reset values.
 * Assumes it is included by bare name from the design files.
 */
`ifndef RTID_REGS_SVH
`define RTID_REGS_SVH

// ----------------------------------------------------------------------------
// Instruction words, ten bits each.
// ----------------------------------------------------------------------------
`define RTID_CODE_CMP_LOAD 10'h239
`define RTID_CODE_RD_IRQ 10'h253
`define RTID_CODE_RD_SER 10'h242
`define RTID_CODE_RD_KEY 10'h256

// ----------------------------------------------------------------------------
// Comparator register field positions.
// ----------------------------------------------------------------------------
`define RTID_CMP_HI_MSB 7
`define RTID_CMP_HI_LSB 4
`define RTID_CMP_LO_MSB 3
`define RTID_CMP_LO_LSB 0

// ----------------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------------
`define RTID_CMP_RST 8'h00
`define RTID_ACC_RST 4'h0

`endif

// *** include/rtid_pkg.sv ***
/*
 * Types shared by the register-transfer instruction decoder files.
 * Assumes rtid_regs.svh is on the include path.
 */
`default_nettype none

package rtid_pkg;

  // --------------------------------------------------------------------------
  // Basic data types.
  // --------------------------------------------------------------------------
  typedef logic [9:0] rtid_instr_t;
  typedef logic [3:0] rtid_nib_t;
  typedef logic [7:0] rtid_cmp_t;

  // One-hot decode of the four transfer instructions.
  typedef struct packed {
    logic cmp_load;
    logic rd_irq;
    logic rd_ser;
    logic rd_key;
  } rtid_op_t;

  // Source registers that the read transfers copy from.
  typedef struct packed {
    rtid_nib_t irq_control_reg;
    rtid_nib_t serial_control_reg;
    rtid_nib_t key_wakeup_reg;
  } rtid_src_t;

endpackage

`default_nettype wire

// *** hdl/rtid_op_decode.sv ***
/*
 * Combinational decode of the instruction word into one-hot operation flags.
 * Assumes the instruction word and its valid come from logic on the core clock.
 */
`default_nettype none
`include "rtid_regs.svh"

module rtid_op_decode
  import rtid_pkg::*;
(
  input wire logic i_valid,
  input wire rtid_instr_t i_instr,
  output rtid_op_t o_op
);

  // --------------------------------------------------------------------------
  // Pattern match.
  // --------------------------------------------------------------------------
  // Each flag is qualified by valid so an idle bus decodes to no operation.
  always_comb begin
    o_op.cmp_load = i_valid && (i_instr == `RTID_CODE_CMP_LOAD);
    o_op.rd_irq = i_valid && (i_instr == `RTID_CODE_RD_IRQ);
    o_op.rd_ser = i_valid && (i_instr == `RTID_CODE_RD_SER);
    o_op.rd_key = i_valid && (i_instr == `RTID_CODE_RD_KEY);
  end

endmodule

`default_nettype wire

// *** hdl/rtid_decode.sv ***
/*
 * Decode and execute of four register-transfer instructions of a 4-bit core:
 * comparator load from B and A, and accumulator reads of the interrupt
 * control, serial control and key wakeup registers.
 * Assumes the fetch unit presents one instruction word per cycle with a
 * valid strobe, and the register file applies the accumulator write pulse.
 */
// Function
// - In comparator mode the comparator load writes B to bits 7..4 and A to bits 3..0.
// - In conversion mode the comparator load changes nothing, like a no-operation.
// - Word 1000111001 is the comparator load, one word and one cycle.
// - Word 1001010011 copies the interrupt control register into A in one cycle.
// - Word 1001000010 copies the serial control register into A in one cycle.
// - The key wakeup read copies the key wakeup register into A in one cycle.
`default_nettype none
`include "rtid_regs.svh"

module rtid_decode
  import rtid_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_instr_valid,
  input wire rtid_instr_t i_instr,
  input wire rtid_nib_t i_acc,
  input wire rtid_nib_t i_reg_b,
  input wire logic i_converter_mode_bit,
  input wire rtid_src_t i_src,
  output logic o_acc_we,
  output rtid_nib_t o_acc_data,
  output logic o_cmp_we,
  output rtid_cmp_t o_cmp_data,
  output logic o_nop_done,
  output logic o_hit,
  output logic o_cy_we,
  output logic o_skip_next
);

  // --------------------------------------------------------------------------
  // Decode.
  // --------------------------------------------------------------------------
  rtid_op_t op;

  rtid_op_decode rtid_op_decode_i (
    .i_valid(i_instr_valid),
    .i_instr(i_instr),
    .o_op(op)
  );

  // --------------------------------------------------------------------------
  // Execute state.
  // --------------------------------------------------------------------------
  logic acc_we_q, acc_we_d;
  rtid_nib_t acc_data_q, acc_data_d;
  logic cmp_we_q, cmp_we_d;
  rtid_cmp_t cmp_q, cmp_d;
  logic nop_q, nop_d;
  logic hit_q, hit_d;
  logic cy_we_q, cy_we_d;
  logic skip_q, skip_d;

  // Next values of every execute register. Write enables are one-cycle pulses,
  // while the comparator register holds its value until the next load.
  always_comb begin
    acc_we_d = 1'b0;
    acc_data_d = acc_data_q;
    cmp_we_d = 1'b0;
    cmp_d = cmp_q;
    nop_d = 1'b0;
    hit_d = op.cmp_load | op.rd_irq | op.rd_ser | op.rd_key;
    // These transfers never touch carry nor request a skip; the flops keep
    // the ports registered so that a later merge with other opcodes is clean.
    cy_we_d = 1'b0;
    skip_d = 1'b0;
    if (op.cmp_load) begin
      if (i_converter_mode_bit) begin
        cmp_we_d = 1'b1;
        cmp_d[`RTID_CMP_HI_MSB:`RTID_CMP_HI_LSB] = i_reg_b;
        cmp_d[`RTID_CMP_LO_MSB:`RTID_CMP_LO_LSB] = i_acc;
      end else begin
        // Conversion mode: the converter owns the register, so touch nothing.
        nop_d = 1'b1;
      end
    end
    if (op.rd_irq) begin
      acc_we_d = 1'b1;
      acc_data_d = i_src.irq_control_reg;
    end
    if (op.rd_ser) begin
      acc_we_d = 1'b1;
      acc_data_d = i_src.serial_control_reg;
    end
    if (op.rd_key) begin
      acc_we_d = 1'b1;
      acc_data_d = i_src.key_wakeup_reg;
    end
  end

  // Registers only; the result appears one cycle after the word is taken.
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      acc_we_q <= 1'b0;
      acc_data_q <= `RTID_ACC_RST;
      cmp_we_q <= 1'b0;
      cmp_q <= `RTID_CMP_RST;
      nop_q <= 1'b0;
      hit_q <= 1'b0;
      cy_we_q <= 1'b0;
      skip_q <= 1'b0;
    end else begin
      acc_we_q <= acc_we_d;
      acc_data_q <= acc_data_d;
      cmp_we_q <= cmp_we_d;
      cmp_q <= cmp_d;
      nop_q <= nop_d;
      hit_q <= hit_d;
      cy_we_q <= cy_we_d;
      skip_q <= skip_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs, all straight from flops.
  // --------------------------------------------------------------------------
  assign o_acc_we = acc_we_q;
  assign o_acc_data = acc_data_q;
  assign o_cmp_we = cmp_we_q;
  assign o_cmp_data = cmp_q;
  assign o_nop_done = nop_q;
  assign o_hit = hit_q;
  assign o_cy_we = cy_we_q;
  assign o_skip_next = skip_q;

  // --------------------------------------------------------------------------
  // Assertions.
  // --------------------------------------------------------------------------
  // Comparator mode load lands B high and A low one cycle later.
  AST_CMP_LOAD: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (i_instr_valid && i_instr == `RTID_CODE_CMP_LOAD && i_converter_mode_bit)
    |=> (o_cmp_we && o_cmp_data == {$past(i_reg_b), $past(i_acc)} && !o_acc_we)
  ) else $error("Comparator load did not store B and A.");

  // Conversion mode load leaves the comparator and accumulator untouched.
  AST_CMP_NOP: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (i_instr_valid && i_instr == `RTID_CODE_CMP_LOAD && !i_converter_mode_bit)
    |=> (!o_cmp_we && !o_acc_we && o_nop_done && $stable(o_cmp_data))
  ) else $error("Comparator load in conversion mode changed state.");

  // The comparator register only moves on a decoded load in comparator mode.
  AST_CMP_HOLD: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    !(i_instr_valid && i_instr == `RTID_CODE_CMP_LOAD && i_converter_mode_bit)
    |=> (!o_cmp_we && $stable(o_cmp_data))
  ) else $error("Comparator register changed without a load.");

  AST_RD_IRQ: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (i_instr_valid && i_instr == `RTID_CODE_RD_IRQ)
    |=> (o_acc_we && o_acc_data == $past(i_src.irq_control_reg) && o_hit)
  ) else $error("Interrupt control read did not reach the accumulator.");

  AST_RD_SER: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (i_instr_valid && i_instr == `RTID_CODE_RD_SER)
    |=> (o_acc_we && o_acc_data == $past(i_src.serial_control_reg) && o_hit)
  ) else $error("Serial control read did not reach the accumulator.");

  AST_RD_KEY: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (i_instr_valid && i_instr == `RTID_CODE_RD_KEY)
    |=> (o_acc_we && o_acc_data == $past(i_src.key_wakeup_reg) && o_hit)
  ) else $error("Key wakeup read did not reach the accumulator.");

  // No transfer writes carry or asks for a skip, for two cycles after it.
  AST_NO_FLAGS: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (i_instr_valid && (i_instr == `RTID_CODE_CMP_LOAD || i_instr == `RTID_CODE_RD_IRQ
      || i_instr == `RTID_CODE_RD_SER || i_instr == `RTID_CODE_RD_KEY))
    |=> (!o_cy_we && !o_skip_next) [*2]
  ) else $error("Transfer touched carry or skip.");

  // Accumulator write pulse appears only for a decoded read transfer.
  AST_ACC_CAUSE: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    o_acc_we |-> $past(i_instr_valid) && ($past(i_instr) == `RTID_CODE_RD_IRQ
      || $past(i_instr) == `RTID_CODE_RD_SER || $past(i_instr) == `RTID_CODE_RD_KEY)
  ) else $error("Accumulator write without a read transfer.");

  // A write pulse to the comparator needs a load seen in comparator mode.
  AST_CMP_CAUSE: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    o_cmp_we |-> $past(i_instr_valid) && $past(i_instr) == `RTID_CODE_CMP_LOAD
      && $past(i_converter_mode_bit)
  ) else $error("Comparator write without a comparator mode load.");

  // A no-operation pulse needs a load seen in conversion mode, and writes nothing.
  AST_NOP_CAUSE: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    o_nop_done |-> $past(i_instr_valid) && $past(i_instr) == `RTID_CODE_CMP_LOAD
      && !$past(i_converter_mode_bit) && !o_cmp_we && !o_acc_we
  ) else $error("No-operation pulse without a conversion mode load.");

  // Only a read transfer may move the accumulator value. The check starts from
  // the word, not from the pulse, so that a reset in mid-run is not taken for a change.
  AST_ACC_HOLD: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    !(i_instr_valid && (i_instr == `RTID_CODE_RD_IRQ || i_instr == `RTID_CODE_RD_SER
      || i_instr == `RTID_CODE_RD_KEY))
    |=> (!o_acc_we && $stable(o_acc_data))
  ) else $error("Accumulator value moved without a read transfer.");

  // Every hit comes from one recognised word one cycle before; other words are ignored.
  AST_HIT_CAUSE: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    o_hit |-> $past(i_instr_valid) && ($past(i_instr) == `RTID_CODE_CMP_LOAD
      || $past(i_instr) == `RTID_CODE_RD_IRQ || $past(i_instr) == `RTID_CODE_RD_SER
      || $past(i_instr) == `RTID_CODE_RD_KEY)
  ) else $error("Hit pulse without a recognised transfer word.");

  // One word executes one transfer, so the two write pulses never meet.
  AST_ONE_WRITE: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    !(o_acc_we && o_cmp_we)
  ) else $error("Accumulator and comparator written in the same cycle.");

endmodule

`default_nettype wire

// *** verification/tb.sv ***
/*
 * Self-checking testbench of the register-transfer instruction decoder.
 * Assumes rtid_pkg is compiled first and rtid_decode carries its own assertions.
 */
`default_nettype none

module tb
  import rtid_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // --------------------------------------------------------------------------
  // Stimulus and observed signals.
  // --------------------------------------------------------------------------
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic valid = 1'b0;
  rtid_instr_t instr = 10'h000;
  rtid_nib_t acc = 4'h0;
  rtid_nib_t reg_b = 4'h0;
  logic mode = 1'b0;
  rtid_src_t src = 12'h000;
  logic acc_we, cmp_we, nop_done, hit, cy_we, skip_next;
  rtid_nib_t acc_data;
  rtid_cmp_t cmp_data;
  int fails = 0;
  int checks_done = 0;

  rtid_decode rtid_decode_i (
    .i_core_clk(core_clk), .i_rstn(rstn), .i_instr_valid(valid), .i_instr(instr),
    .i_acc(acc), .i_reg_b(reg_b), .i_converter_mode_bit(mode), .i_src(src),
    .o_acc_we(acc_we), .o_acc_data(acc_data), .o_cmp_we(cmp_we), .o_cmp_data(cmp_data),
    .o_nop_done(nop_done), .o_hit(hit), .o_cy_we(cy_we), .o_skip_next(skip_next)
  );

  // Free-running core clock, 10 ns period.
  initial begin
    forever #5 core_clk = ~core_clk;
  end

  // --------------------------------------------------------------------------
  // Shared helpers.
  // --------------------------------------------------------------------------
  // Inputs move 1 ns after the rising edge so no race with the design's flops.
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask

  task automatic put(input logic v, input rtid_instr_t c, input logic m,
                     input rtid_nib_t b, input rtid_nib_t a);
    valid = v;
    instr = c;
    mode = m;
    reg_b = b;
    acc = a;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Flag path outputs must stay low whatever executes.
  task automatic pulses(input logic a_we, input logic c_we, input logic nop, input logic h);
    chk("acc_we", {7'h00, a_we}, {7'h00, acc_we});
    chk("cmp_we", {7'h00, c_we}, {7'h00, cmp_we});
    chk("nop_done", {7'h00, nop}, {7'h00, nop_done});
    chk("hit", {7'h00, h}, {7'h00, hit});
    chk("cy_we", 8'h00, {7'h00, cy_we});
    chk("skip_next", 8'h00, {7'h00, skip_next});
  endtask

  task automatic end_sim();
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // Scenarios.
  // --------------------------------------------------------------------------
  // Two loads back to back; the second must not be lost behind the first.
  task automatic s_cmp_load();
    put(1'b1, 10'h239, 1'b1, 4'h5, 4'hA);
    tick();
    put(1'b1, 10'h239, 1'b1, 4'hC, 4'h3);
    pulses(1'b0, 1'b1, 1'b0, 1'b1);
    chk("cmp_data", 8'h5A, cmp_data);
    tick();
    put(1'b0, 10'h239, 1'b1, 4'h0, 4'h0);
    chk("cmp_data", 8'hC3, cmp_data);
    tick();
    pulses(1'b0, 1'b0, 1'b0, 1'b0);
  endtask

  // In conversion mode the load must leave the comparator and accumulator alone.
  // A still holds 3h, the key wakeup value that the read scenario wrote last.
  task automatic s_cmp_nop();
    put(1'b1, 10'h239, 1'b0, 4'hF, 4'hF);
    tick();
    put(1'b0, 10'h000, 1'b0, 4'h0, 4'h0);
    pulses(1'b0, 1'b0, 1'b1, 1'b1);
    chk("cmp_data", 8'hC3, cmp_data);
    chk("acc_data", 8'h03, {4'h0, acc_data});
    tick();
    pulses(1'b0, 1'b0, 1'b0, 1'b0);
  endtask

  // The three reads issued every cycle with distinct source values.
  task automatic s_reads();
    rtid_instr_t codes [3];
    rtid_nib_t exp [3];
    codes = '{10'h253, 10'h242, 10'h256};
    exp = '{4'h9, 4'h6, 4'h3};
    src.irq_control_reg = 4'h9;
    src.serial_control_reg = 4'h6;
    src.key_wakeup_reg = 4'h3;
    for (int i = 0; i < 3; i++) begin
      put(1'b1, codes[i], 1'b1, 4'hE, 4'hE);
      tick();
      pulses(1'b1, 1'b0, 1'b0, 1'b1);
      chk("acc_data", {4'h0, exp[i]}, {4'h0, acc_data});
    end
    put(1'b0, 10'h000, 1'b0, 4'h0, 4'h0);
    tick();
    pulses(1'b0, 1'b0, 1'b0, 1'b0);
    chk("acc_data", 8'h03, {4'h0, acc_data});
  endtask

  // A neighbouring word (238h) and an unqualified load must produce nothing.
  task automatic s_ignore();
    put(1'b1, 10'h238, 1'b1, 4'h1, 4'h2);
    tick();
    put(1'b0, 10'h239, 1'b1, 4'h1, 4'h2);
    pulses(1'b0, 1'b0, 1'b0, 1'b0);
    tick();
    put(1'b0, 10'h000, 1'b0, 4'h0, 4'h0);
    pulses(1'b0, 1'b0, 1'b0, 1'b0);
    chk("cmp_data", 8'hC3, cmp_data);
  endtask

  // A reset in mid-run clears both registers and drops a word shown under it;
  // a load in the first cycle after release must still be taken.
  task automatic s_reset();
    tick();
    rstn = 1'b0;
    put(1'b1, 10'h253, 1'b1, 4'h0, 4'h0);
    tick();
    rstn = 1'b1;
    put(1'b1, 10'h239, 1'b1, 4'h7, 4'hE);
    pulses(1'b0, 1'b0, 1'b0, 1'b0);
    chk("cmp_data", 8'h00, cmp_data);
    chk("acc_data", 8'h00, {4'h0, acc_data});
    tick();
    put(1'b0, 10'h000, 1'b0, 4'h0, 4'h0);
    pulses(1'b0, 1'b1, 1'b0, 1'b1);
    chk("cmp_data", 8'h7E, cmp_data);
    tick();
    pulses(1'b0, 1'b0, 1'b0, 1'b0);
  endtask

  // --------------------------------------------------------------------------
  // Main sequence and hang guard.
  // --------------------------------------------------------------------------
  initial begin
    repeat (16) tick();
    rstn = 1'b1;
    pulses(1'b0, 1'b0, 1'b0, 1'b0);
    chk("cmp_data", 8'h00, cmp_data);
    chk("acc_data", 8'h00, {4'h0, acc_data});
    s_cmp_load();
    s_reads();
    s_cmp_nop();
    s_ignore();
    s_reset();
    end_sim();
  end

  initial begin
    repeat (2000) @(posedge core_clk);
    fails++;
    end_sim();
  end

endmodule

`default_nettype wire
